/* fan_period_meter.sv */
`timescale 1ns/100ps

module fan_period_meter #(
   parameter int TICK_CYC = spb_msg_pkg::FB_TICK_CYC
) (
   input  wire logic        clk_i,     // System clock.
   input  wire logic        rst_n_i,   // Asynchronous reset, active low.
   input  wire logic        tach_i,    // Fan tachometer pulse, synchronous.
   output logic [15:0]      period_o   // Rotation period in 2.56 us counts.
);

   generate
      if (TICK_CYC < 2 || TICK_CYC > 1024) begin : g_bad_tick
         $error("fan_period_meter: TICK_CYC out of range");
      end
   endgenerate

   typedef struct packed {
      logic        tach_d;
      logic [9:0]  div;
      logic [15:0] ticks;
      logic [15:0] period;
   } meter_state_t;

   localparam logic [9:0] DIV_LAST = 10'(TICK_CYC - 1);

   meter_state_t s_r;
   meter_state_t s_nxt;
   logic         tach_rise;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tach_d = tach_i;
      tach_rise = tach_i && !s_r.tach_d;
      if (s_r.div == DIV_LAST) begin
         s_nxt.div = 10'h000;
         if (s_r.ticks != spb_msg_pkg::FB_NO_ROTATION) begin
            s_nxt.ticks = s_r.ticks + 16'h0001;
         end
      end else begin
         s_nxt.div = s_r.div + 10'h001;
      end
      if (tach_rise) begin
         // A period is known only once a full revolution has been timed.
         s_nxt.period = s_r.ticks;
         s_nxt.ticks = 16'h0000;
         // The edge cycle itself is part of the first tick, so a period of
         // whole ticks is not read one count short.
         s_nxt.div = 10'h001;
      end else if (s_r.ticks == spb_msg_pkg::FB_NO_ROTATION) begin
         s_nxt.period = spb_msg_pkg::FB_NO_ROTATION;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '{tach_d: 1'b0, div: 10'h000, ticks: 16'hffff, period: 16'hffff};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign period_o = s_r.period;

   a_fb_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tach_i && !s_r.tach_d) |=> (period_o == $past(s_r.ticks)) && (s_r.ticks == 16'h0000))
      else $error("fan period not captured on tach edge");

   a_fb_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_r.ticks == 16'hffff && !tach_i) |=> period_o == 16'hffff)
      else $error("stalled fan not reported as all ones");

endmodule

/* mgmt_node_model.sv */
`timescale 1ns/100ps

// Stands in for the management node: it sends frames and drains replies.
module mgmt_node_model (
   input  wire logic                  clk_i,      // System clock.
   input  wire spb_msg_pkg::tx_beat_t tx_i,       // Reply byte from the block.
   input  wire logic                  stall_i,    // Take reply bytes only every other cycle.
   output spb_msg_pkg::rx_beat_t      rx_o,       // Frame byte to the block.
   output logic                       tx_ready_o  // Reply byte may be taken.
);
   logic [7:0] reply_q[$];
   int         replies;

   initial begin
      rx_o = '0;
      tx_ready_o = 1'b1;
      replies = 0;
   end

   always @(posedge clk_i) begin
      if (tx_i.valid && tx_ready_o) begin
         reply_q.push_back(tx_i.data);
         if (tx_i.last)
            replies <= replies + 1;
      end
      tx_ready_o <= #1 stall_i ? ~tx_ready_o : 1'b1;
   end

   // Bytes go out one per cycle; afterwards the data lines carry junk so
   // that nothing can lean on a stale value.
   task automatic send(input logic [7:0] b [8], input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         #1 rx_o = '{valid: 1'b1, first: i == 0, last: i == n - 1, data: b[i]};
      end
      @(posedge clk_i);
      #1 rx_o = '{valid: 1'b0, first: 1'b0, last: 1'b0, data: ~b[n - 1]};
   endtask
endmodule

/* seat_power_msg_ctrl.sv */
`timescale 1ns/100ps

module seat_power_msg_ctrl #(
   parameter int FB_TICK_CYC = spb_msg_pkg::FB_TICK_CYC
) (
   input  wire logic                      clk_i,         // System clock, 200 MHz.
   input  wire logic                      rst_n_i,       // Asynchronous reset, active low.
   input  wire spb_msg_pkg::rx_beat_t     rx_i,          // Received frame byte.
   output logic                           rx_ready_o,    // High while frames are accepted.
   input  wire logic                      fan_tach_i,    // Fan tachometer pulse.
   input  wire logic                      tx_ready_i,    // Reply sink can take a byte.
   output spb_msg_pkg::tx_beat_t          tx_o,          // Reply frame byte.
   output spb_msg_pkg::thermal_cfg_t      thermal_cfg_o, // Loaded thermal limits.
   output logic                           fan_on_o,      // Fan control discrete.
   output spb_msg_pkg::port_cfg_t         port_cfg_o     // Ethernet port enables.
);

   typedef struct packed {
      spb_msg_pkg::msg_state_t      st;
      logic [3:0]                   pos;
      logic                         bad;
      logic [7:0]                   cmd;
      logic [7:0]                   len;
      logic [4:0][7:0]              body;
      spb_msg_pkg::thermal_cfg_t    therm;
      logic                         fan_on;
      spb_msg_pkg::port_cfg_t       ports;
      logic [spb_msg_pkg::TX_BYTES-1:0][7:0] tx_buf;
      logic [3:0]                   tx_cnt;
      logic [3:0]                   tx_idx;
      spb_msg_pkg::tx_beat_t        tx;
      logic                         rx_ready;
   } ctl_state_t;

   ctl_state_t  s_r;
   ctl_state_t  s_nxt;
   logic [15:0] fb_period;
   logic [3:0]  pos;
   logic [2:0]  body_idx;
   logic        frame_end;
   logic        do_therm;
   logic        do_toggle;
   logic        do_fan_q;
   logic        do_port_set;
   logic        do_port_q;
   logic [3:0]  next_idx;

   // The meter always runs so a reply never waits for a fresh measurement.
   fan_period_meter #(
      .TICK_CYC (FB_TICK_CYC)
   ) u_meter (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .tach_i   (fan_tach_i),
      .period_o (fb_period)
   );

   always_comb begin
      s_nxt = s_r;
      pos = rx_i.first ? spb_msg_pkg::POS_PROTO : s_r.pos;
      body_idx = 3'(pos - spb_msg_pkg::POS_DATA);
      frame_end = 1'b0;
      do_therm = 1'b0;
      do_toggle = 1'b0;
      do_fan_q = 1'b0;
      do_port_set = 1'b0;
      do_port_q = 1'b0;
      next_idx = s_r.tx_idx + 4'h1;

      if (s_r.st == spb_msg_pkg::ST_SEND) begin
         // Reply bytes are held until the sink takes them.
         if (tx_ready_i) begin
            if (s_r.tx.last) begin
               s_nxt.st = spb_msg_pkg::ST_IDLE;
               s_nxt.tx.valid = 1'b0;
               s_nxt.tx.last = 1'b0;
               s_nxt.rx_ready = 1'b1;
            end else begin
               s_nxt.tx_idx = next_idx;
               s_nxt.tx.data = s_r.tx_buf[3'(next_idx)];
               s_nxt.tx.last = (next_idx == s_r.tx_cnt - 4'h1);
            end
         end
      end else if (rx_i.valid && (rx_i.first || s_r.st == spb_msg_pkg::ST_RECV)) begin
         s_nxt.st = spb_msg_pkg::ST_RECV;
         if (rx_i.first) begin
            s_nxt.bad = 1'b0;
         end
         if (pos != spb_msg_pkg::POS_MAX) begin
            s_nxt.pos = pos + 4'h1;
         end
         if (pos == spb_msg_pkg::POS_PROTO) begin
            s_nxt.bad = (rx_i.data != spb_msg_pkg::PROTO_ID);
         end else if (pos == spb_msg_pkg::POS_CMD) begin
            s_nxt.cmd = rx_i.data;
         end else if (pos == spb_msg_pkg::POS_LEN) begin
            s_nxt.len = rx_i.data;
         end else if (body_idx < 3'(spb_msg_pkg::BODY_BYTES) &&
                      pos < 4'(spb_msg_pkg::POS_DATA + spb_msg_pkg::BODY_BYTES)) begin
            s_nxt.body[body_idx] = rx_i.data;
         end else begin
            s_nxt.bad = 1'b1;
         end
         if (rx_i.last) begin
            s_nxt.st = spb_msg_pkg::ST_IDLE;
            s_nxt.pos = spb_msg_pkg::POS_PROTO;
            // The frame must end exactly where its length byte says.
            frame_end = !s_nxt.bad && pos >= spb_msg_pkg::POS_LEN &&
                        ({4'h0, pos} == s_nxt.len + 8'h02);
         end
      end

      if (frame_end) begin
         if (s_nxt.cmd == spb_msg_pkg::CMD_THERM_CFG &&
             s_nxt.len == spb_msg_pkg::LEN_THERM_CFG) begin
            do_therm = 1'b1;
         end else if (s_nxt.cmd == spb_msg_pkg::CMD_FAN_TOGGLE &&
                      s_nxt.len == spb_msg_pkg::LEN_NO_DATA) begin
            do_toggle = 1'b1;
         end else if (s_nxt.cmd == spb_msg_pkg::CMD_FAN_QUERY &&
                      s_nxt.len == spb_msg_pkg::LEN_NO_DATA) begin
            do_fan_q = 1'b1;
         end else if (s_nxt.cmd == spb_msg_pkg::CMD_PORT &&
                      s_nxt.len == spb_msg_pkg::LEN_PORT_SET &&
                      {s_nxt.body[0], s_nxt.body[1], s_nxt.body[2]} ==
                      spb_msg_pkg::SUB_PORT_SET) begin
            // Values other than 0 or 1 are not a valid setting and drop the frame.
            do_port_set = (s_nxt.body[3][7:1] == 7'h00) &&
                          (s_nxt.body[4][7:1] == 7'h00);
         end else if (s_nxt.cmd == spb_msg_pkg::CMD_PORT &&
                      s_nxt.len == spb_msg_pkg::LEN_PORT_QUERY &&
                      {s_nxt.body[0], s_nxt.body[1], s_nxt.body[2]} ==
                      spb_msg_pkg::SUB_PORT_QUERY) begin
            do_port_q = 1'b1;
         end
      end

      if (do_therm) begin
         s_nxt.therm.shed_limit = s_nxt.body[0];
         s_nxt.therm.reconnect_limit = s_nxt.body[1];
         s_nxt.therm.fan_on_limit = s_nxt.body[2];
         s_nxt.therm.fan_off_limit = s_nxt.body[3];
         s_nxt.therm.shed_interval_min = s_nxt.body[4];
      end
      if (do_toggle) begin
         s_nxt.fan_on = !s_r.fan_on;
      end
      if (do_port_set) begin
         // The applied setting is also the one held for the next query.
         s_nxt.ports.down1_en = s_nxt.body[3][0];
         s_nxt.ports.down2_en = s_nxt.body[4][0];
      end
      if (do_fan_q) begin
         s_nxt.tx_buf = '0;
         s_nxt.tx_buf[0] = spb_msg_pkg::PROTO_ID;
         s_nxt.tx_buf[1] = spb_msg_pkg::CMD_FAN_REPLY;
         s_nxt.tx_buf[2] = spb_msg_pkg::LEN_FAN_REPLY;
         s_nxt.tx_buf[3] = {7'h00, s_r.fan_on};
         s_nxt.tx_buf[4] = fb_period[15:8];
         s_nxt.tx_buf[5] = fb_period[7:0];
         s_nxt.tx_cnt = spb_msg_pkg::TX_LEN_FAN;
      end
      if (do_port_q) begin
         s_nxt.tx_buf[0] = spb_msg_pkg::PROTO_ID;
         s_nxt.tx_buf[1] = spb_msg_pkg::CMD_PORT;
         s_nxt.tx_buf[2] = spb_msg_pkg::LEN_PORT_REPLY;
         s_nxt.tx_buf[3] = spb_msg_pkg::SUB_PORT_REPLY[23:16];
         s_nxt.tx_buf[4] = spb_msg_pkg::SUB_PORT_REPLY[15:8];
         s_nxt.tx_buf[5] = spb_msg_pkg::SUB_PORT_REPLY[7:0];
         s_nxt.tx_buf[6] = {7'h00, s_r.ports.down1_en};
         s_nxt.tx_buf[7] = {7'h00, s_r.ports.down2_en};
         s_nxt.tx_cnt = spb_msg_pkg::TX_LEN_PORT;
      end
      if (do_fan_q || do_port_q) begin
         // The reply starts on the next cycle, far inside the one-second limit;
         // input is refused until the last reply byte is taken.
         s_nxt.st = spb_msg_pkg::ST_SEND;
         s_nxt.rx_ready = 1'b0;
         s_nxt.tx_idx = 4'h0;
         s_nxt.tx.valid = 1'b1;
         s_nxt.tx.last = 1'b0;
         s_nxt.tx.data = spb_msg_pkg::PROTO_ID;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
         s_r.st <= spb_msg_pkg::ST_IDLE;
         s_r.therm <= {5{spb_msg_pkg::RST_LIMIT}};
         s_r.fan_on <= spb_msg_pkg::RST_FAN_ON;
         s_r.ports.upstream_en <= spb_msg_pkg::RST_UPSTREAM;
         s_r.ports.down1_en <= spb_msg_pkg::RST_DOWNSTREAM;
         s_r.ports.down2_en <= spb_msg_pkg::RST_DOWNSTREAM;
         s_r.rx_ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rx_ready_o = s_r.rx_ready;
   assign tx_o = s_r.tx;
   assign thermal_cfg_o = s_r.therm;
   assign fan_on_o = s_r.fan_on;
   assign port_cfg_o = s_r.ports;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_therm_load: assert property (
      do_therm |=> thermal_cfg_o == {$past(s_nxt.body[0]), $past(s_nxt.body[1]),
                                     $past(s_nxt.body[2]), $past(s_nxt.body[3]),
                                     $past(s_nxt.body[4])})
      else $error("thermal limits not loaded in order");

   a_fan_toggle: assert property (
      do_toggle |=> fan_on_o != $past(fan_on_o))
      else $error("fan state not inverted");

   a_fan_reply_start: assert property (
      do_fan_q |=> tx_o.valid && tx_o.data == 8'h01 && !rx_ready_o)
      else $error("fan query did not start a reply");

   a_fan_reply_body: assert property (
      do_fan_q |=> s_r.tx_buf[1] == 8'haa && s_r.tx_buf[2] == 8'h03 &&
                   s_r.tx_cnt == 4'h6 && s_r.tx_buf[5] == $past(fb_period[7:0]))
      else $error("fan reply header or feedback wrong");

   a_fan_state_byte: assert property (
      do_fan_q |=> s_r.tx_buf[3] == {7'h00, $past(fan_on_o)})
      else $error("fan state byte wrong");

   a_port_apply: assert property (
      do_port_set |=> port_cfg_o.down1_en == $past(s_nxt.body[3][0]) &&
                      port_cfg_o.down2_en == $past(s_nxt.body[4][0]))
      else $error("port setting not applied");

   a_port_powerup: assert property (
      !$past(rst_n_i) |-> port_cfg_o == 3'b100)
      else $error("port enables wrong after reset");

   a_port_reply: assert property (
      do_port_q |=> s_r.tx_cnt == 4'h8 && s_r.tx_buf[1] == 8'hf4 &&
                    {s_r.tx_buf[3], s_r.tx_buf[4], s_r.tx_buf[5]} == 24'h524543 &&
                    s_r.tx_buf[6][0] == $past(port_cfg_o.down1_en))
      else $error("port reply contents wrong");

   a_discard_frame: assert property (
      (rx_i.valid && rx_i.last && s_r.st != spb_msg_pkg::ST_SEND &&
       !(do_therm || do_toggle || do_fan_q || do_port_set || do_port_q))
      |=> $stable(fan_on_o) && $stable(port_cfg_o) && $stable(thermal_cfg_o) && !tx_o.valid)
      else $error("bad frame changed state or replied");

   a_tx_hold: assert property (
      (tx_o.valid && !tx_ready_i) |=> tx_o.valid && $stable(tx_o.data) && $stable(tx_o.last))
      else $error("reply byte dropped under back-pressure");

   a_reply_end: assert property (
      (tx_o.valid && tx_ready_i && tx_o.last) |=> !tx_o.valid && rx_ready_o)
      else $error("reply did not end after its last byte");

   a_fan_reply_high: assert property (
      do_fan_q |=> s_r.tx_buf[4] == $past(fb_period[15:8]))
      else $error("fan feedback high byte wrong");

   a_port_reply_start: assert property (
      do_port_q |=> tx_o.valid && tx_o.data == 8'h01 && s_r.st == spb_msg_pkg::ST_SEND)
      else $error("port query did not start a reply");

   a_port_reply_two: assert property (
      do_port_q |=> s_r.tx_buf[7] == {7'h00, $past(port_cfg_o.down2_en)} &&
                    s_r.tx_buf[2] == 8'h05 && s_r.tx_buf[0] == 8'h01)
      else $error("port reply enable bytes wrong");

   a_fan_stable: assert property (
      !do_toggle |=> $stable(fan_on_o))
      else $error("fan state changed without a toggle");

   a_ports_stable: assert property (
      !do_port_set |=> $stable(port_cfg_o))
      else $error("port enables changed without a set frame");

   a_upstream_kept: assert property (
      port_cfg_o.upstream_en)
      else $error("upstream port not enabled");

endmodule

/* spb_msg_pkg.sv */
package spb_msg_pkg;

   // Message framing.
   localparam logic [7:0]  PROTO_ID        = 8'h01;
   localparam logic [7:0]  CMD_THERM_CFG   = 8'ha7;
   localparam logic [7:0]  CMD_FAN_TOGGLE  = 8'ha8;
   localparam logic [7:0]  CMD_FAN_QUERY   = 8'ha9;
   localparam logic [7:0]  CMD_FAN_REPLY   = 8'haa;
   localparam logic [7:0]  CMD_PORT        = 8'hf4;
   localparam logic [7:0]  LEN_THERM_CFG   = 8'h05;
   localparam logic [7:0]  LEN_NO_DATA     = 8'h00;
   localparam logic [7:0]  LEN_FAN_REPLY   = 8'h03;
   localparam logic [7:0]  LEN_PORT_SET    = 8'h05;
   localparam logic [7:0]  LEN_PORT_QUERY  = 8'h03;
   localparam logic [7:0]  LEN_PORT_REPLY  = 8'h05;
   localparam logic [23:0] SUB_PORT_SET    = 24'h534543;
   localparam logic [23:0] SUB_PORT_QUERY  = 24'h454352;
   localparam logic [23:0] SUB_PORT_REPLY  = 24'h524543;

   // Byte positions inside a frame; data bytes start after the length byte.
   localparam logic [3:0]  POS_PROTO       = 4'h0;
   localparam logic [3:0]  POS_CMD         = 4'h1;
   localparam logic [3:0]  POS_LEN         = 4'h2;
   localparam logic [3:0]  POS_DATA        = 4'h3;
   localparam logic [3:0]  POS_MAX         = 4'hf;
   localparam int          BODY_BYTES      = 5;
   localparam int          TX_BYTES        = 8;
   localparam logic [3:0]  TX_LEN_FAN      = 4'h6;
   localparam logic [3:0]  TX_LEN_PORT     = 4'h8;

   // Reset values.
   localparam logic [7:0]  RST_LIMIT       = 8'h00;
   localparam logic        RST_FAN_ON      = 1'b0;
   localparam logic        RST_UPSTREAM    = 1'b1;
   localparam logic        RST_DOWNSTREAM  = 1'b0;

   // Fan feedback: one count is 256/100000 ms, i.e. 2560 ns.
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          FB_TICK_NS      = 2560;
   localparam int          FB_TICK_CYC     = FB_TICK_NS / CLK_PERIOD_NS;
   localparam logic [15:0] FB_NO_ROTATION  = 16'hffff;

   typedef struct packed {
      logic [7:0] shed_limit;
      logic [7:0] reconnect_limit;
      logic [7:0] fan_on_limit;
      logic [7:0] fan_off_limit;
      logic [7:0] shed_interval_min;
   } thermal_cfg_t;

   typedef struct packed {
      logic upstream_en;
      logic down1_en;
      logic down2_en;
   } port_cfg_t;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic [7:0] data;
   } rx_beat_t;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } tx_beat_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RECV = 2'b01,
      ST_SEND = 2'b10
   } msg_state_t;

endpackage

/* tb.sv */
`timescale 1ns/100ps

module tb;
   localparam int TICK = 4;
   typedef logic [7:0] frame_t [8];

   logic                       clk_i;
   logic                       rst_n_i;
   logic                       fan_tach_i;
   logic                       stall;
   logic                       rx_ready;
   logic                       tx_ready;
   logic                       fan_on;
   spb_msg_pkg::rx_beat_t      rx_beat;
   spb_msg_pkg::tx_beat_t      tx_beat;
   spb_msg_pkg::thermal_cfg_t  thermal_cfg;
   spb_msg_pkg::port_cfg_t     port_cfg;
   int                         fail_count;
   int                         samples_checked;

   seat_power_msg_ctrl #(.FB_TICK_CYC(TICK)) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .rx_i(rx_beat), .rx_ready_o(rx_ready),
      .fan_tach_i(fan_tach_i), .tx_ready_i(tx_ready), .tx_o(tx_beat),
      .thermal_cfg_o(thermal_cfg), .fan_on_o(fan_on), .port_cfg_o(port_cfg));

   mgmt_node_model node_u (
      .clk_i(clk_i), .tx_i(tx_beat), .stall_i(stall), .rx_o(rx_beat),
      .tx_ready_o(tx_ready));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp_val(input logic [39:0] got, input logic [39:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
         fail_count++;
      end
   endtask

   function automatic frame_t fr(input logic [63:0] v);
      for (int i = 0; i < 8; i++)
         fr[i] = v[63 - 8 * i -: 8];
   endfunction

   // Sends a frame and checks the reply; en of zero means none may come.
   task automatic exchange(input logic [63:0] f, input int fn, input logic [63:0] e,
                           input int en);
      int     r0;
      int     w;
      frame_t eb;
      r0 = node_u.replies;
      eb = fr(e);
      node_u.reply_q.delete();
      node_u.send(fr(f), fn);
      cmp_val(rx_ready, 40'(en == 0), "ready while replying");
      for (w = 0; w < 300 && (en == 0 || node_u.replies == r0); w++) begin
         @(posedge clk_i);
         #1;
      end
      if (en > 0 && w == 300) begin
         $display("unexpected at %0t: no reply", $time);
         fail_count++;
         complete_run();
      end else begin
         cmp_val(node_u.reply_q.size(), en, "reply length");
         for (int i = 0; i < en && i < node_u.reply_q.size(); i++)
            cmp_val(node_u.reply_q[i], eb[i], "reply byte");
         cmp_val(rx_ready, 40'h1, "ready after reply");
         repeat (2) @(posedge clk_i);
         #1;
      end
   endtask

   task automatic reset_values();
      cmp_val(thermal_cfg, 40'h0, "thermal after reset");
      cmp_val(fan_on, 1'b0, "fan after reset");
      cmp_val(port_cfg, 3'b100, "ports after reset");
      exchange(64'h01a9_0000_0000_0000, 3, 64'h01aa_0300_ffff_0000, 6);
   endtask

   task automatic fan_toggle_query();
      stall = 1'b1;
      exchange(64'h01a8_0000_0000_0000, 3, 64'h0, 0);
      cmp_val(fan_on, 1'b1, "fan after toggle");
      exchange(64'h01a9_0000_0000_0000, 3, 64'h01aa_0301_ffff_0000, 6);
      exchange(64'h01a8_0000_0000_0000, 3, 64'h0, 0);
      cmp_val(fan_on, 1'b0, "fan after second toggle");
      exchange(64'h02a8_0000_0000_0000, 3, 64'h0, 0);
      exchange(64'h01a8_0000_0000_0000, 4, 64'h0, 0);
      cmp_val(fan_on, 1'b0, "fan after bad toggle frames");
      stall = 1'b0;
   endtask

   task automatic thermal_load();
      exchange(64'h01a7_0511_2233_4455, 8, 64'h0, 0);
      cmp_val(thermal_cfg, 40'h11_2233_4455, "thermal limits");
      exchange(64'h01a7_0466_7788_9900, 7, 64'h0, 0);
      cmp_val(thermal_cfg, 40'h11_2233_4455, "short thermal frame");
   endtask

   task automatic port_cfg_rw();
      exchange(64'h01f4_0553_4543_0100, 8, 64'h0, 0);
      cmp_val(port_cfg, 3'b110, "ports set 1 0");
      exchange(64'h01f4_0345_4352_0000, 6, 64'h01f4_0552_4543_0100, 8);
      exchange(64'h01f4_0553_4543_0001, 8, 64'h0, 0);
      cmp_val(port_cfg, 3'b101, "ports set 0 1");
      exchange(64'h01f4_0345_4352_0000, 6, 64'h01f4_0552_4543_0001, 8);
      exchange(64'h01f4_0553_4544_0101, 8, 64'h0, 0);
      exchange(64'h01f4_0553_4543_0201, 8, 64'h0, 0);
      exchange(64'h01f4_0445_4352_0000, 7, 64'h0, 0);
      exchange(64'h01b0_0000_0000_0000, 3, 64'h0, 0);
      cmp_val(port_cfg, 3'b101, "ports after bad frames");
   endtask

   // A reset in mid-run must bring back the factory port setting and clear the limits.
   task automatic mid_reset();
      @(posedge clk_i);
      #1 rst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      cmp_val(port_cfg, 3'b100, "ports after second reset");
      cmp_val(thermal_cfg, 40'h0, "thermal after second reset");
      cmp_val(fan_on, 1'b0, "fan after second reset");
      exchange(64'h01f4_0345_4352_0000, 6, 64'h01f4_0552_4543_0000, 8);
   endtask

   // Tach edges every 40 cycles give 10 counts with the shortened tick.
   task automatic fan_period();
      for (int k = 0; k < 5; k++) begin
         repeat (39) @(posedge clk_i);
         #1 fan_tach_i = 1'b1;
         @(posedge clk_i);
         #1 fan_tach_i = 1'b0;
      end
      exchange(64'h01a9_0000_0000_0000, 3, 64'h01aa_0300_000a_0000, 6);
   endtask

   initial begin
      fail_count = 0;
      samples_checked = 0;
      rst_n_i = 1'b0;
      fan_tach_i = 1'b0;
      stall = 1'b0;
      repeat (8) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      reset_values();
      fan_toggle_query();
      thermal_load();
      port_cfg_rw();
      mid_reset();
      fan_period();
      complete_run();
   end
endmodule
